// file: verilog/cdm_monitor.sv
`timescale 1ns/1ns
// Notes on behaviour
// - reference missing flag when enabled, external
// - reference missing also raises summary fault
// - filter overflow flags fault, clamps result
// - twenty identical modulator bits flag fault
// - offset outside window: keep coefficient, flag
// - gain calibration overflow: keep gain, flag
// - fault flag with result update, write-one clears
// - separate input range enables and flags
// - one reference range flag, either pin
// - range flags sticky, write-one clears
// - tally increments every 131 clocks
// - tally wraps to zero
// - oscillator stops in standby unless duty cycling or keep alive
module cdm_monitor (
	input wire logic core_clk, // core clock
	input wire logic reset, // async reset, high
	input wire logic ref_detect_on, // reference detect enable
	input wire logic ext_ref_sel, // external reference selected
	input wire logic ref_low, // comparator: reference low or open
	input wire logic adc_check_on, // converter error check enable
	input wire logic pos_input_range_check_on, // positive input range enable
	input wire logic neg_input_range_check_on, // negative input range enable
	input wire logic ref_range_check_on, // reference range enable
	input wire logic clock_monitor_on, // clock tally enable
	input wire logic pos_input_over, // positive_input above supply
	input wire logic pos_input_under, // positive_input below supply
	input wire logic neg_input_over, // negative_input above supply
	input wire logic neg_input_under, // negative_input below supply
	input wire logic refp_over, // reference_input_pair plus above supply
	input wire logic refm_under, // reference_input_pair minus below supply
	input wire logic mod_valid, // modulator bit strobe
	input wire logic mod_bit, // modulator bit
	input wire logic conv_valid, // filter result strobe
	input wire logic [cdm_pkg::CDM_RESULT_W-1:0] conv_value, // filter result
	input wire logic conv_over, // filter overflow
	input wire logic conv_under, // filter underflow
	input wire logic ofs_cal_done, // offset calibration result strobe
	input wire logic [cdm_pkg::CDM_RESULT_W-1:0] ofs_cal_value, // new offset
	input wire logic gain_cal_done, // gain calibration result strobe
	input wire logic [cdm_pkg::CDM_RESULT_W-1:0] gain_cal_value, // new gain
	input wire logic gain_cal_over, // filter overflow during gain cal
	input wire logic standby, // converter in standby
	input wire logic duty_cycling, // duty cycling mode
	input wire logic osc_keep_alive, // keep oscillator on in standby
	input wire logic clr_ref_missing, // write one clears
	input wire logic clr_adc_fault, // write one clears
	input wire logic clr_pos_range, // write one clears
	input wire logic clr_neg_range, // write one clears
	input wire logic clr_ref_range, // write one clears
	output logic ref_missing_flag, // reference missing flag
	output logic adc_fault_flag, // converter fault flag
	output logic pos_input_range_flag, // positive input range flag
	output logic neg_input_range_flag, // negative input range flag
	output logic ref_range_flag, // reference range flag
	output logic summary_fault, // summary fault status
	output logic [cdm_pkg::CDM_RESULT_W-1:0] conv_result, // result register
	output logic [cdm_pkg::CDM_RESULT_W-1:0] offset_coef, // offset register
	output logic [cdm_pkg::CDM_RESULT_W-1:0] gain_coef, // gain register
	output logic [cdm_pkg::CDM_TALLY_W-1:0] clock_tally, // clock tally register
	output logic osc_enable // internal oscillator enable
);
	import cdm_pkg::*;

	typedef struct packed {
		logic ref_missing;
		logic adc_fault;
		logic pos_rng;
		logic neg_rng;
		logic ref_rng;
		logic summary;
		logic [CDM_RESULT_W-1:0] result;
		logic [CDM_RESULT_W-1:0] ofs;
		logic [CDM_RESULT_W-1:0] gain;
		logic [CDM_TALLY_W-1:0] tally;
		logic [CDM_DIV_W-1:0] div;
		logic [CDM_RUN_W-1:0] run;
		logic last_bit;
		logic sat_pend;
		logic cal_pend;
		logic osc;
	} cdm_state_t;

	cdm_state_t st;
	cdm_state_t next_st;
	logic sat_now;
	logic ofs_bad;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_st = st;
		sat_now = 1'b0;
		ofs_bad = 1'b0;
		if (mod_valid) begin
			next_st.last_bit = mod_bit;
			if (mod_bit == st.last_bit && st.run != 5'(CDM_SAT_RUN)) begin
				next_st.run = st.run + 5'd1;
			end else if (mod_bit != st.last_bit) begin
				next_st.run = 5'd1;
			end
			// saturation keeps flagging while the run lasts
			sat_now = (mod_bit == st.last_bit) && (st.run >= 5'(CDM_SAT_RUN - 1));
		end
		if (adc_check_on && sat_now) begin
			next_st.sat_pend = 1'b1;
		end
		ofs_bad = ($signed(ofs_cal_value) > $signed(CDM_OFS_MAX))
			|| ($signed(ofs_cal_value) < $signed(CDM_OFS_MIN));
		if (ofs_cal_done) begin
			if (ofs_bad && adc_check_on) begin
				next_st.cal_pend = 1'b1;
			end else if (!ofs_bad) begin
				next_st.ofs = ofs_cal_value;
			end
		end
		if (gain_cal_done) begin
			if (gain_cal_over) begin
				if (adc_check_on) begin
					next_st.cal_pend = 1'b1;
				end
			end else begin
				next_st.gain = gain_cal_value;
			end
		end
		if (clr_adc_fault) begin
			next_st.adc_fault = 1'b0;
		end
		// clamp and flag on filter overflow
		if (conv_valid) begin
			next_st.result = conv_over ? CDM_CLAMP_HIGH
				: (conv_under ? CDM_CLAMP_LOW : conv_value);
			// pends raised in this same cycle must not be lost
			if (adc_check_on && (conv_over || conv_under || next_st.sat_pend
					|| next_st.cal_pend)) begin
				next_st.adc_fault = 1'b1;
			end
			next_st.sat_pend = 1'b0;
			next_st.cal_pend = 1'b0;
		end
		if (clr_ref_missing) begin
			next_st.ref_missing = 1'b0;
		end
		if (ref_detect_on && ext_ref_sel && ref_low) begin
			next_st.ref_missing = 1'b1;
		end
		if (clr_pos_range) begin
			next_st.pos_rng = 1'b0;
		end
		if (pos_input_range_check_on && (pos_input_over || pos_input_under)) begin
			next_st.pos_rng = 1'b1;
		end
		if (clr_neg_range) begin
			next_st.neg_rng = 1'b0;
		end
		if (neg_input_range_check_on && (neg_input_over || neg_input_under)) begin
			next_st.neg_rng = 1'b1;
		end
		if (clr_ref_range) begin
			next_st.ref_rng = 1'b0;
		end
		if (ref_range_check_on && (refp_over || refm_under)) begin
			next_st.ref_rng = 1'b1;
		end
		next_st.summary = (next_st.ref_missing && ref_detect_on)
			|| (next_st.adc_fault && adc_check_on)
			|| (next_st.pos_rng && pos_input_range_check_on)
			|| (next_st.neg_rng && neg_input_range_check_on)
			|| (next_st.ref_rng && ref_range_check_on);
		if (clock_monitor_on) begin
			if (st.div == 8'(CDM_DIV_CYCLES - 1)) begin
				next_st.div = '0;
				next_st.tally = st.tally + 8'd1;
			end else begin
				next_st.div = st.div + 8'd1;
			end
		end
		next_st.osc = !standby || duty_cycling || osc_keep_alive;
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			st <= '{ofs: CDM_OFS_RESET, gain: CDM_GAIN_RESET, result: CDM_RESULT_RESET,
				osc: 1'b1, default: '0};
		end else begin
			st <= next_st;
		end
	end

	assign ref_missing_flag = st.ref_missing;
	assign adc_fault_flag = st.adc_fault;
	assign pos_input_range_flag = st.pos_rng;
	assign neg_input_range_flag = st.neg_rng;
	assign ref_range_flag = st.ref_rng;
	assign summary_fault = st.summary;
	assign conv_result = st.result;
	assign offset_coef = st.ofs;
	assign gain_coef = st.gain;
	assign clock_tally = st.tally;
	assign osc_enable = st.osc;

	// ****************************************
	// checks
	// ****************************************
	property p_ref_set;
		@(posedge core_clk) disable iff (reset)
		ref_detect_on && ext_ref_sel && ref_low |=> ref_missing_flag;
	endproperty
	a_ref_set: assert property (p_ref_set) else $error("reference flag not set");

	property p_summary;
		@(posedge core_clk) disable iff (reset)
		ref_detect_on && ext_ref_sel && ref_low |=> summary_fault;
	endproperty
	a_summary: assert property (p_summary) else $error("summary not set");

	property p_clamp;
		@(posedge core_clk) disable iff (reset)
		conv_valid && conv_over |=> conv_result == CDM_CLAMP_HIGH;
	endproperty
	a_clamp: assert property (p_clamp) else $error("overflow not clamped");

	property p_conv_flag;
		@(posedge core_clk) disable iff (reset)
		conv_valid && adc_check_on && conv_under |=> adc_fault_flag;
	endproperty
	a_conv_flag: assert property (p_conv_flag) else $error("conv fault missed");

	property p_ofs_keep;
		@(posedge core_clk) disable iff (reset)
		ofs_cal_done && ofs_bad |=> $stable(offset_coef);
	endproperty
	a_ofs_keep: assert property (p_ofs_keep) else $error("offset updated");

	property p_gain_keep;
		@(posedge core_clk) disable iff (reset)
		gain_cal_done && gain_cal_over |=> $stable(gain_coef);
	endproperty
	a_gain_keep: assert property (p_gain_keep) else $error("gain updated");

	property p_fault_sticky;
		@(posedge core_clk) disable iff (reset)
		adc_fault_flag && !clr_adc_fault |=> adc_fault_flag;
	endproperty
	a_fault_sticky: assert property (p_fault_sticky) else $error("fault dropped");

	property p_fault_at_result;
		@(posedge core_clk) disable iff (reset)
		!adc_fault_flag && !conv_valid |=> !adc_fault_flag;
	endproperty
	a_fault_at_result: assert property (p_fault_at_result) else $error("fault off result");

	property p_sat_pend;
		@(posedge core_clk) disable iff (reset)
		adc_check_on && sat_now |=> st.sat_pend || adc_fault_flag;
	endproperty
	a_sat_pend: assert property (p_sat_pend) else $error("saturation missed");

	property p_neg_rng;
		@(posedge core_clk) disable iff (reset)
		neg_input_range_check_on && (neg_input_over || neg_input_under) |=> neg_input_range_flag;
	endproperty
	a_neg_rng: assert property (p_neg_rng) else $error("neg range missed");

	property p_rng_off;
		@(posedge core_clk) disable iff (reset)
		!pos_input_range_check_on && !pos_input_range_flag |=> !pos_input_range_flag;
	endproperty
	a_rng_off: assert property (p_rng_off) else $error("disabled flag set");

	property p_ref_rng;
		@(posedge core_clk) disable iff (reset)
		ref_range_check_on && refm_under |=> ref_range_flag;
	endproperty
	a_ref_rng: assert property (p_ref_rng) else $error("ref range missed");

	property p_tally;
		@(posedge core_clk) disable iff (reset)
		clock_monitor_on && st.div == 8'(CDM_DIV_CYCLES - 1)
			|=> clock_tally == $past(clock_tally) + 8'h01;
	endproperty
	a_tally: assert property (p_tally) else $error("tally step wrong");

	property p_osc;
		@(posedge core_clk) disable iff (reset)
		standby && !duty_cycling && !osc_keep_alive |=> !osc_enable;
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator not stopped");

	c_clamp: cover property (@(posedge core_clk) conv_valid && conv_over);
	c_sat: cover property (@(posedge core_clk) sat_now && adc_check_on);
	c_tally_wrap: cover property (@(posedge core_clk) clock_tally == 8'hFF
		&& st.div == 8'(CDM_DIV_CYCLES - 1));
	c_ref_clr: cover property (@(posedge core_clk) ref_missing_flag && clr_ref_missing);
endmodule : cdm_monitor

// file: verilog/cdm_pkg.sv
package cdm_pkg;
	// ****************************************
	// sizes and counts
	// ****************************************
	localparam int CDM_RESULT_W = 24;
	localparam int CDM_TALLY_W = 8;
	localparam int CDM_SAT_RUN = 20;
	localparam int CDM_DIV_CYCLES = 131;
	localparam int CDM_RUN_W = 5;
	localparam int CDM_DIV_W = 8;
	// ****************************************
	// offset calibration window, signed 24 bit
	// ****************************************
	localparam logic [23:0] CDM_OFS_MAX = 24'h07_FFFF;
	localparam logic [23:0] CDM_OFS_MIN = 24'hF7_FFFF;
	localparam logic [23:0] CDM_OFS_RESET = 24'h00_0000;
	localparam logic [23:0] CDM_GAIN_RESET = 24'h40_0000;
	localparam logic [23:0] CDM_RESULT_RESET = 24'h00_0000;
	localparam logic [23:0] CDM_CLAMP_LOW = 24'h00_0000;
	localparam logic [23:0] CDM_CLAMP_HIGH = 24'hFF_FFFF;
endpackage : cdm_pkg

// file: verification/cdm_testbench.sv
`timescale 1ns/1ns
module testbench;
	import cdm_pkg::*;
	logic core_clk, reset, ref_detect_on, ext_ref_sel, ref_low, adc_check_on;
	logic pos_input_range_check_on, neg_input_range_check_on, ref_range_check_on;
	logic clock_monitor_on, pos_input_over, pos_input_under, neg_input_over;
	logic neg_input_under, refp_over, refm_under, mod_valid, mod_bit, conv_valid;
	logic conv_over, conv_under, ofs_cal_done, gain_cal_done, gain_cal_over;
	logic standby, duty_cycling, osc_keep_alive, clr_ref_missing, clr_adc_fault;
	logic clr_pos_range, clr_neg_range, clr_ref_range, osc_enable, summary_fault;
	logic ref_missing_flag, adc_fault_flag, pos_input_range_flag;
	logic neg_input_range_flag, ref_range_flag;
	logic [CDM_RESULT_W-1:0] conv_value, ofs_cal_value, gain_cal_value;
	logic [CDM_RESULT_W-1:0] conv_result, offset_coef, gain_coef, exp_ofs;
	logic [CDM_TALLY_W-1:0] clock_tally;
	logic [23:0] ofs_tab [4] = '{24'hF7_FFFF, 24'h08_0000, 24'h07_FFFF, 24'hF7_FFFE};
	int failures = 0;
	int checks = 0;

	cdm_monitor i_cdm_monitor (.*);

	initial begin
		core_clk = 1'h0;
		forever #50 core_clk = ~core_clk;
	end
	// ****************************************
	// access tasks
	// ****************************************
	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc
	task automatic conv(input logic [23:0] v, input logic o, input logic u);
		@(posedge core_clk) {conv_valid, conv_value, conv_over, conv_under} <= {1'h1, v, o, u};
		@(posedge core_clk) {conv_valid, conv_over, conv_under} <= 3'h0;
		#1;
	endtask : conv
	task automatic clr_adc;
		@(posedge core_clk) clr_adc_fault <= 1'h1;
		@(posedge core_clk) clr_adc_fault <= 1'h0;
		#1;
	endtask : clr_adc
	task automatic mods(input int n, input logic b);
		@(posedge core_clk) {mod_valid, mod_bit} <= {1'h1, b};
		cyc(n);
		mod_valid <= 1'h0;
	endtask : mods
	task automatic cal(input logic g, input logic [23:0] v, input logic o);
		@(posedge core_clk);
		if (g) {gain_cal_done, gain_cal_value, gain_cal_over} <= {1'h1, v, o};
		else {ofs_cal_done, ofs_cal_value} <= {1'h1, v};
		@(posedge core_clk) {gain_cal_done, ofs_cal_done, gain_cal_over} <= 3'h0;
		#1;
	endtask : cal
	task print_verdict;
		if (failures == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict
	initial begin
		#4_000_000;
		failures++;
		print_verdict;
	end
	// ****************************************
	// tests
	// ****************************************
	initial begin
		{ref_detect_on, ext_ref_sel, ref_low, adc_check_on, clock_monitor_on} = 5'h00;
		{pos_input_range_check_on, neg_input_range_check_on, ref_range_check_on} = 3'h0;
		{pos_input_over, pos_input_under, neg_input_over, neg_input_under} = 4'h0;
		{refp_over, refm_under, mod_valid, mod_bit, conv_valid, conv_over} = 6'h00;
		{conv_under, ofs_cal_done, gain_cal_done, gain_cal_over, standby} = 5'h00;
		{duty_cycling, osc_keep_alive, clr_ref_missing, clr_adc_fault} = 4'h0;
		{clr_pos_range, clr_neg_range, clr_ref_range} = 3'h0;
		{conv_value, ofs_cal_value, gain_cal_value} = 72'h0;
		reset = 1'h1;
		cyc(16);
		reset <= 1'h0;
		#1;
		chk("gain_coef", CDM_GAIN_RESET, gain_coef);
		chk("offset_coef", CDM_OFS_RESET, offset_coef);
		chk("osc_enable", 1'h1, osc_enable);
		@(posedge core_clk) {ref_low, ext_ref_sel} <= 2'h3;
		cyc(2); #1 chk("ref_missing_flag", 1'h0, ref_missing_flag);
		@(posedge core_clk) {ref_detect_on, ext_ref_sel} <= 2'h2;
		cyc(2); #1 chk("ref_missing_flag", 1'h0, ref_missing_flag);
		@(posedge core_clk) ext_ref_sel <= 1'h1;
		cyc(2); #1 chk("ref_missing_flag", 1'h1, ref_missing_flag);
		chk("summary_fault", 1'h1, summary_fault);
		@(posedge core_clk) standby <= 1'h1;
		@(posedge core_clk) standby <= 1'h0;
		@(posedge core_clk) {ref_low, clr_ref_missing} <= 2'h1;
		@(posedge core_clk) clr_ref_missing <= 1'h0;
		#1 chk("ref_missing_flag", 1'h0, ref_missing_flag);
		cyc(1); #1 chk("summary_fault", 1'h0, summary_fault);
		@(posedge core_clk) adc_check_on <= 1'h1;
		conv(24'h12_3456, 1'h1, 1'h0);
		chk("conv_result", CDM_CLAMP_HIGH, conv_result);
		chk("adc_fault_flag", 1'h1, adc_fault_flag);
		conv(24'h12_3456, 1'h0, 1'h0);
		chk("conv_result", 24'h12_3456, conv_result);
		chk("adc_fault_flag", 1'h1, adc_fault_flag);
		clr_adc;
		chk("adc_fault_flag", 1'h0, adc_fault_flag);
		conv(24'h12_3456, 1'h0, 1'h1);
		chk("conv_result", CDM_CLAMP_LOW, conv_result);
		chk("adc_fault_flag", 1'h1, adc_fault_flag);
		clr_adc;
		mods(19, 1'h1);
		mods(1, 1'h0);
		conv(24'h00_0001, 1'h0, 1'h0);
		chk("adc_fault_flag", 1'h0, adc_fault_flag);
		mods(20, 1'h1);
		conv(24'h00_0001, 1'h0, 1'h0);
		chk("adc_fault_flag", 1'h1, adc_fault_flag);
		clr_adc;
		for (int i = 0; i < 4; i++) begin
			cal(1'h0, ofs_tab[i], 1'h0);
			exp_ofs = (i % 2 == 0) ? ofs_tab[i] : ofs_tab[i-1];
			chk("offset_coef", exp_ofs, offset_coef);
			conv(24'h00_0001, 1'h0, 1'h0);
			chk("adc_fault_flag", 24'(i % 2), adc_fault_flag);
			clr_adc;
		end
		cal(1'h1, 24'h20_0000, 1'h0);
		chk("gain_coef", 24'h20_0000, gain_coef);
		cal(1'h1, 24'h30_0000, 1'h1);
		chk("gain_coef", 24'h20_0000, gain_coef);
		conv(24'h00_0001, 1'h0, 1'h0);
		chk("adc_fault_flag", 1'h1, adc_fault_flag);
		clr_adc;
		@(posedge core_clk) adc_check_on <= 1'h0;
		conv(24'h00_0001, 1'h1, 1'h0);
		chk("adc_fault_flag", 1'h0, adc_fault_flag);
		@(posedge core_clk) {pos_input_over, neg_input_under, refm_under} <= 3'h7;
		cyc(2); #1 chk("pos_input_range_flag", 1'h0, pos_input_range_flag);
		@(posedge core_clk) pos_input_range_check_on <= 1'h1;
		cyc(2); #1 chk("pos_input_range_flag", 1'h1, pos_input_range_flag);
		chk("neg_input_range_flag", 1'h0, neg_input_range_flag);
		chk("ref_range_flag", 1'h0, ref_range_flag);
		@(posedge core_clk) {neg_input_range_check_on, ref_range_check_on} <= 2'h3;
		cyc(2); #1 chk("neg_input_range_flag", 1'h1, neg_input_range_flag);
		chk("ref_range_flag", 1'h1, ref_range_flag);
		@(posedge core_clk) {pos_input_over, neg_input_under, refm_under} <= 3'h0;
		cyc(3); #1 chk("ref_range_flag", 1'h1, ref_range_flag);
		@(posedge core_clk) {clr_pos_range, clr_ref_range} <= 2'h3;
		@(posedge core_clk) {clr_pos_range, clr_ref_range} <= 2'h0;
		#1 chk("pos_input_range_flag", 1'h0, pos_input_range_flag);
		chk("neg_input_range_flag", 1'h1, neg_input_range_flag);
		chk("ref_range_flag", 1'h0, ref_range_flag);
		@(posedge core_clk) {pos_input_under, neg_input_over, refp_over} <= 3'h7;
		cyc(2); #1 chk("pos_input_range_flag", 1'h1, pos_input_range_flag);
		chk("ref_range_flag", 1'h1, ref_range_flag);
		for (int i = 0; i < 8; i++) begin
			@(posedge core_clk) {standby, duty_cycling, osc_keep_alive} <= i[2:0];
			cyc(2); #1 chk("osc_enable", i != 4, osc_enable);
		end
		@(posedge core_clk) {standby, clock_monitor_on} <= 2'h1;
		cyc(CDM_DIV_CYCLES - 1); #1 chk("clock_tally", 8'h00, clock_tally);
		cyc(1); #1 chk("clock_tally", 8'h01, clock_tally);
		cyc(CDM_DIV_CYCLES * 255 - 1); #1 chk("clock_tally", 8'hFF, clock_tally);
		cyc(1); #1 chk("clock_tally", 8'h00, clock_tally);
		print_verdict;
	end
endmodule : testbench
